// >>> rtl/kbc_pkg.sv
// Shared constants for the keyboard attachment control decoder.
// Assumes a 32-bit classic Wishbone register bus and a 20 MHz core clock.
package kbc_pkg;
   // Register byte offsets
   localparam logic [3:0] OFF_CMD = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_IRQ_EN = 4'h8;
   localparam logic [3:0] OFF_IRQ_CLR = 4'hC;
   // Command register field positions
   localparam int CMD_CTRL_LSB = 0;
   localparam int CMD_FUNC_LSB = 8;
   localparam int CMD_MOD_BIT = 11;
   localparam int CMD_LOAD_BIT = 12;
   // Status register bit positions
   localparam int ST_LOCKED = 0;
   localparam int ST_PARITY = 1;
   localparam int ST_IEN = 2;
   localparam int ST_REQ = 3;
   localparam int ST_IRQ = 4;
   localparam int ST_CMD_LIGHTS = 5;
   localparam int ST_FIELD_LIGHTS = 6;
   localparam int ST_BADFMT = 7;
   localparam int ST_W = 8;
   localparam int ST_EV_LSB = 8;
   // Event bits for the sticky status
   localparam int EV_DONE = 0;
   localparam int EV_BADFMT = 1;
   localparam int EV_PARITY = 2;
   localparam int EV_W = 3;
   // Control-byte nibbles
   localparam logic [1:0] HI_DIAG = 2'h2;
   localparam logic [1:0] HI_PARITY = 2'h1;
   localparam logic [1:0] HI_BASIC = 2'h0;
   localparam logic [3:0] LO_NONE = 4'h0;
   localparam logic [3:0] LO_LOCK = 4'h8;
   localparam logic [3:0] LO_UNLOCK = 4'h4;
   localparam logic [3:0] LO_ENABLE = 4'h2;
   localparam logic [3:0] LO_DROP_REQ = 4'h1;
   // Reset values
   localparam logic RST_LOCKED = 1'b0;
   localparam logic [EV_W-1:0] RST_EV_EN = 3'h0;
endpackage

// >>> rtl/kbc_decode.sv
// Combinational decode of one keyboard control byte into action strobes.
// Assumes the caller qualifies the strobes with a valid command.
`timescale 1ns/1ps
module kbc_decode (
   // Control byte
   input wire logic [7:0] ctrl_i,
   // Actions
   output logic set_req_o,
   output logic clr_parity_o,
   output logic lock_o,
   output logic unlock_o,
   output logic set_ien_o,
   output logic clr_ien_o,
   output logic drop_req_o
);
   logic [1:0] hi;
   logic [3:0] lo;
   always_comb begin
      hi = ctrl_i[5:4];
      lo = ctrl_i[3:0];
      set_req_o = (hi == kbc_pkg::HI_DIAG) && (lo == kbc_pkg::LO_NONE);
      clr_parity_o = (hi == kbc_pkg::HI_PARITY) && (lo == kbc_pkg::LO_NONE);
      lock_o = (hi == kbc_pkg::HI_BASIC) && (lo == kbc_pkg::LO_LOCK);
      unlock_o = (hi == kbc_pkg::HI_BASIC) && (lo == kbc_pkg::LO_UNLOCK);
      set_ien_o = (hi == kbc_pkg::HI_BASIC) && (lo == kbc_pkg::LO_ENABLE);
      clr_ien_o = (hi == kbc_pkg::HI_BASIC) && (lo == kbc_pkg::LO_NONE);
      drop_req_o = (hi == kbc_pkg::HI_BASIC) && (lo == kbc_pkg::LO_DROP_REQ);
   end
endmodule

// >>> rtl/kbc_top.sv
// Keyboard attachment control decoder with a Wishbone register port.
// Assumes a classic Wishbone master, one clock, synchronous active-high reset.
//
// Overview of operation
// - Control byte XX10 0000 sets the keyboard interrupt request as a diagnostic.
// - Control byte XX01 0000 clears the latched parity-check condition.
// - Control byte XX00 1000 drops the bail and locks the keyboard.
// - Control byte XX00 0100 picks up the bail and unlocks the keyboard.
// - Control byte XX00 0010 enables and XX00 0000 disables keyboard interrupts.
// - Control byte XX00 0001 drops the pending request and keeps the enable state.
// - A load command with function X00 turns command lights off, X01 on, X1X toggles field lights.
`timescale 1ns/1ps
module kbc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Keyboard side
   input wire logic parity_err_i,
   output logic kbd_locked_o,
   output logic cmd_lights_o,
   output logic field_lights_o,
   output logic kbd_irq_o,
   output logic irq_o
);
   logic locked_q, locked_d, parity_q, parity_d, ien_q, ien_d, req_q, req_d;
   logic cmdl_q, cmdl_d, fldl_q, fldl_d, bad_q, bad_d;
   logic kirq_q, kirq_d, irq_q, irq_d, ack_q, ack_d;
   logic [31:0] rd_q, rd_d;
   logic [kbc_pkg::EV_W-1:0] ev_q, ev_d, en_q, en_d, ev_set;
   logic set_req, clr_par, lock, unlock, set_ien, clr_ien, drop_req;
   logic req_hit, wr, cmd_wr, is_load, fmt_ok;
   logic [2:0] func;

   kbc_decode u_dec (
      .ctrl_i(dat_i[kbc_pkg::CMD_CTRL_LSB +: 8]),
      .set_req_o(set_req),
      .clr_parity_o(clr_par),
      .lock_o(lock),
      .unlock_o(unlock),
      .set_ien_o(set_ien),
      .clr_ien_o(clr_ien),
      .drop_req_o(drop_req)
   );

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   always_comb begin
      req_hit = cyc_i && stb_i && !ack_q;
      wr = req_hit && we_i && sel_i[0];
      cmd_wr = wr && hit(adr_i, kbc_pkg::OFF_CMD);
      is_load = dat_i[kbc_pkg::CMD_LOAD_BIT];
      func = dat_i[kbc_pkg::CMD_FUNC_LSB +: 3];
      // A start with modifier or function set is flagged, not executed
      fmt_ok = !dat_i[kbc_pkg::CMD_MOD_BIT] && (func == 3'h0);
      locked_d = locked_q;
      parity_d = parity_q;
      ien_d = ien_q;
      req_d = req_q;
      cmdl_d = cmdl_q;
      fldl_d = fldl_q;
      bad_d = bad_q;
      ev_set = '0;
      if (cmd_wr && is_load) begin
         if (func[1]) begin
            fldl_d = !fldl_q;
         end else begin
            cmdl_d = func[0];
         end
         ev_set[kbc_pkg::EV_DONE] = 1'b1;
      end else if (cmd_wr && !fmt_ok) begin
         bad_d = 1'b1;
         ev_set[kbc_pkg::EV_BADFMT] = 1'b1;
      end else if (cmd_wr) begin
         bad_d = 1'b0;
         if (lock) locked_d = 1'b1;
         if (unlock) locked_d = 1'b0;
         if (set_ien) ien_d = 1'b1;
         if (clr_ien) ien_d = 1'b0;
         if (drop_req) req_d = 1'b0;
         if (set_req) req_d = 1'b1;
         if (clr_par) parity_d = 1'b0;
         ev_set[kbc_pkg::EV_DONE] = 1'b1;
      end
      // A new parity error outranks a clear in the same cycle
      if (parity_err_i) begin
         parity_d = 1'b1;
         ev_set[kbc_pkg::EV_PARITY] = 1'b1;
      end
      // Built from the next values so the line never lags the status bits it mirrors
      kirq_d = req_d && ien_d;
      en_d = en_q;
      if (wr && hit(adr_i, kbc_pkg::OFF_IRQ_EN)) en_d = dat_i[kbc_pkg::EV_W-1:0];
      ev_d = ev_q;
      if (wr && hit(adr_i, kbc_pkg::OFF_IRQ_CLR)) ev_d = ev_q & ~dat_i[kbc_pkg::EV_W-1:0];
      ev_d = ev_d | ev_set;
      irq_d = |(ev_d & en_d);
      // One wait state: ack follows the taking edge and falls on the next one
      ack_d = req_hit;
      rd_d = '0;
      if (req_hit && !we_i) begin
         case (adr_i)
            kbc_pkg::OFF_STATUS: begin
               rd_d[kbc_pkg::ST_LOCKED] = locked_q;
               rd_d[kbc_pkg::ST_PARITY] = parity_q;
               rd_d[kbc_pkg::ST_IEN] = ien_q;
               rd_d[kbc_pkg::ST_REQ] = req_q;
               rd_d[kbc_pkg::ST_IRQ] = kirq_q;
               rd_d[kbc_pkg::ST_CMD_LIGHTS] = cmdl_q;
               rd_d[kbc_pkg::ST_FIELD_LIGHTS] = fldl_q;
               rd_d[kbc_pkg::ST_BADFMT] = bad_q;
               rd_d[kbc_pkg::ST_EV_LSB +: kbc_pkg::EV_W] = ev_q;
            end
            kbc_pkg::OFF_IRQ_EN: begin
               rd_d[kbc_pkg::EV_W-1:0] = en_q;
            end
            default: begin
               rd_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         locked_q <= kbc_pkg::RST_LOCKED;
         parity_q <= 1'b0;
         ien_q <= 1'b0;
         req_q <= 1'b0;
         cmdl_q <= 1'b0;
         fldl_q <= 1'b0;
         bad_q <= 1'b0;
         kirq_q <= 1'b0;
         irq_q <= 1'b0;
         ack_q <= 1'b0;
         rd_q <= '0;
         ev_q <= '0;
         en_q <= kbc_pkg::RST_EV_EN;
      end else begin
         locked_q <= locked_d;
         parity_q <= parity_d;
         ien_q <= ien_d;
         req_q <= req_d;
         cmdl_q <= cmdl_d;
         fldl_q <= fldl_d;
         bad_q <= bad_d;
         kirq_q <= kirq_d;
         irq_q <= irq_d;
         ack_q <= ack_d;
         rd_q <= rd_d;
         ev_q <= ev_d;
         en_q <= en_d;
      end
   end

   assign dat_o = rd_q;
   assign ack_o = ack_q;
   assign kbd_locked_o = locked_q;
   assign cmd_lights_o = cmdl_q;
   assign field_lights_o = fldl_q;
   assign kbd_irq_o = kirq_q;
   assign irq_o = irq_q;

   // Command decode checks
   a_diag_sets_req: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h20 |=> req_q)
      else $error("diagnostic command did not raise request");
   a_parity_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h10 && !parity_err_i |=> !parity_q)
      else $error("parity condition not cleared");
   a_parity_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      parity_err_i |=> parity_q)
      else $error("parity error not latched");
   a_lock_kbd: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h08 |=> kbd_locked_o)
      else $error("keyboard not locked");
   a_unlock_kbd: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h04 |=> !kbd_locked_o)
      else $error("keyboard not unlocked");
   a_enable_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h00 |=> !ien_q ##1 !kbd_irq_o)
      else $error("disable did not clear enable");
   a_enable_set: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h02 |=> ien_q)
      else $error("enable command did not set enable");
   a_drop_keeps_en: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && fmt_ok && dat_i[5:0] == 6'h01 |=> !req_q && ien_q == $past(ien_q))
      else $error("drop request changed enable or kept request");
   a_bad_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && !is_load && !fmt_ok |=> bad_q && $stable(locked_q) && $stable(ien_q)
      && $stable(req_q))
      else $error("badly formed start was executed");
   a_lights_on: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && is_load && func[1:0] == 2'h1 |=> cmd_lights_o)
      else $error("command lights not turned on");
   a_field_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr && is_load && func[1] |=> field_lights_o != $past(field_lights_o))
      else $error("field lights did not switch");
   a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      kbd_irq_o == (req_q && ien_q))
      else $error("keyboard interrupt does not follow enabled request");

   // Bus and event interrupt checks
   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acknowledged in one cycle");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("acknowledge held longer than one cycle");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(ev_q & en_q))
      else $error("interrupt line does not match enabled events");
endmodule

// >>> verification/kbc_chan.sv
// Channel model: one classic Wishbone access for each go pulse.
// Assumes the slave answers; the bench bounds the wait.
`timescale 1ns/1ps
module kbc_chan (
   // Clock
   input wire logic clk_i,
   // Bench request
   input wire logic go_i,
   input wire logic we_i,
   input wire logic bad_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] wd_i,
   output logic done_o = 1'b0,
   output logic [31:0] rd_o = 32'h0,
   // Wishbone master
   output logic cyc_o = 1'b0,
   output logic stb_o = 1'b0,
   output logic we_o = 1'b0,
   output logic [3:0] adr_o = 4'h0,
   output logic [3:0] sel_o = 4'h0,
   output logic [31:0] dat_o = 32'h0,
   input wire logic ack_i,
   input wire logic [31:0] dat_i
);
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (cyc_o && ack_i) begin
         {cyc_o, stb_o, sel_o} <= 6'h00;
         rd_o <= dat_i;
         done_o <= 1'b1;
         // Released data is no longer valid, so show its inverse
         dat_o <= ~dat_o;
      end else if (go_i && !cyc_o) begin
         {cyc_o, stb_o, sel_o} <= 6'h3F;
         we_o <= we_i;
         adr_o <= adr_i;
         if (!we_i || adr_i != 4'h0 || wd_i[12] || bad_i) begin
            dat_o <= wd_i;
         end else begin
            dat_o <= {wd_i[31:12], 4'h0, wd_i[7:0]};
         end
      end
   end
endmodule

// >>> verification/keyboard_attachment_control_decode_test.sv
// Bench for the keyboard control decoder: command table, then hand cases.
// Assumes kbc_chan drives the register port as the issuing channel.
`timescale 1ns/1ps
module keyboard_attachment_control_decode_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic go = 1'b0, we = 1'b0, bad = 1'b0, perr = 1'b0;
   logic [3:0] adr = 4'h0, wadr, sel;
   logic [31:0] wd = 32'h0, rd, wdat, rdat;
   logic done, cyc, stb, wem, ack, lck, cml, fdl, kirq, irq;
   int failures = 0;
   int compares = 0;
   logic [23:0] rows [12] = '{24'h000801, 24'h000400, 24'h002008, 24'h00021C,
      24'h000104, 24'h00E01C, 24'h000008, 24'h000100, 24'h110020, 24'h140000,
      24'h120040, 24'h160000};
   always #25 clk_i = ~clk_i;
   kbc_chan chan (.clk_i(clk_i), .go_i(go), .we_i(we), .bad_i(bad), .adr_i(adr),
      .wd_i(wd), .done_o(done), .rd_o(rd), .cyc_o(cyc), .stb_o(stb), .we_o(wem),
      .adr_o(wadr), .sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
   kbc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(wem),
      .adr_i(wadr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .parity_err_i(perr), .kbd_locked_o(lck), .cmd_lights_o(cml),
      .field_lights_o(fdl), .kbd_irq_o(kirq), .irq_o(irq));
   task automatic results();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      we <= w;
      adr <= a;
      wd <= d;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      while (done !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 20) failures++;
      @(posedge clk_i);
   endtask
   initial begin
      #(50 * 4000);
      failures++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      acc(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0);
      acc(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         acc(1'b1, 4'h0, {16'h0, rows[i][23:8]});
         acc(1'b0, 4'h4, 32'h0);
         chk(rd[6:0], rows[i][6:0]);
         chk({fdl, cml, kirq, lck}, {rows[i][6:4], rows[i][0]});
      end
      $display("table test done");
      perr <= 1'b1;
      @(posedge clk_i);
      perr <= 1'b0;
      acc(1'b1, 4'h8, 32'h7);
      acc(1'b0, 4'h4, 32'h0);
      chk(rd & 32'h402, 32'h402);
      chk({31'h0, irq}, 32'h1);
      acc(1'b1, 4'h0, 32'h10);
      acc(1'b1, 4'hC, 32'h7);
      acc(1'b0, 4'h4, 32'h0);
      chk({rd[1], rd[10:8], irq}, 5'h00);
      $display("parity test done");
      acc(1'b1, 4'h0, 32'h2);
      bad <= 1'b1;
      acc(1'b1, 4'h0, 32'h900);
      bad <= 1'b0;
      acc(1'b0, 4'h4, 32'h0);
      chk(rd & 32'h284, 32'h284);
      chk({31'h0, irq}, 32'h1);
      acc(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      acc(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h7);
      $display("refusal test done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      acc(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("mid-run reset test done");
      results();
   end
endmodule
